// file: ssb_softstart_brake.sv
// Softstart, DC brake and fault sequencer with relays, LEDs and register port
//
// What this block does
// - during softstart the conducted level on two phases rises gradually
// - at full speed the bypass relay closes around the semiconductors
// - a stop from the switch starts braking for the set braking time
// - buttons give separate start/stop; separate variant splits start and brake inputs
// - relay one on with an accepted start, off once braking has finished
// - on any fault relay one drops together with the semiconductors
// - softstop and separate variants switch relay one with the bypass
// - relay two energises once the unit is ready after power-up
// - thyristor heat, phase loss, sequence, motor heat drop relay two, switch off
// - temperature faults stay latched until the supply is cycled
// - phase faults stay latched until the supply is cycled
// - bimetal contact overtemperature switches off and drops relay two
// - thermistor heat, short or open wire switch off and drop both relays
// - after a fault reset the unit stays stopped until a fresh start
// - green LED steady with supply, flashing while starting or braking
// - relay-one LED steady whenever relay one is on
// - relay-two LED steady when on, else flashes fault code as one to eight pulses
// - pulse counts map to the eight fault causes in fixed order
// - ramp time 1 to 20 s, starting torque 20 to 80 percent
// - braking time 1 to 20 s, braking begins 0.5 s after the stop
// - a 200 ms recovery follows each cycle before a new start
// - a start during braking abandons braking and begins a new softstart
// - with buttons, start and stop within 0.1 s gives the stop priority
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module ssb_softstart_brake
  import ssb_pkg::*;
#(
  parameter logic [31:0] P_SEC_CYC = SEC_CYC,
  parameter logic [31:0] P_BRAKE_DELAY_CYC = BRAKE_DELAY_CYC,
  parameter logic [31:0] P_RECOVER_CYC = RECOVER_CYC,
  parameter logic [31:0] P_SIMUL_CYC = SIMUL_CYC,
  parameter logic [31:0] P_FLASH_CYC = FLASH_CYC,
  parameter logic [31:0] P_FLASH_PAUSE_CYC = FLASH_PAUSE_CYC,
  parameter logic [31:0] P_GREEN_BLINK_CYC = GREEN_BLINK_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic START_IN,
  input wire logic BRAKE_IN,
  input wire logic AUX_SUPPLY_OK,
  input wire logic THY_OVERTEMP,
  input wire logic HEATSINK_SENSOR_FAIL,
  input wire logic PHASE_FAIL,
  input wire logic PHASE_SEQ_ERR,
  input wire logic FREQ_ERR,
  input wire logic BIMETAL_OPEN,
  input wire logic THERM_OVERTEMP,
  input wire logic THERM_SHORT,
  input wire logic THERM_OPEN,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic [6:0] FIRE_LEVEL,
  output logic SEMI_ON,
  output logic BYPASS_ON,
  output logic BRAKE_ON,
  output logic RELAY1_ON,
  output logic RELAY2_ON,
  output logic LED_GREEN,
  output logic LED_RELAY1,
  output logic LED_RELAY2
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] clamp_secs(input logic [4:0] v);
    if (v < TIME_MIN_S) begin
      return TIME_MIN_S;
    end else if (v > TIME_MAX_S) begin
      return TIME_MAX_S;
    end
    return v;
  endfunction

  function automatic logic [31:0] secs_cycles(input logic [4:0] s);
    return {27'h0, s} * P_SEC_CYC;
  endfunction

  // ----------------------------------------------------------------
  // Registers and settings
  // ----------------------------------------------------------------
  logic [31:0] config_ff;
  ssb_state_t state_ff;
  logic [3:0] code_ff;
  logic [6:0] level_ff;
  logic ready_ff;
  ssb_variant_t variant;
  logic sensor_en;
  logic [4:0] ramp_s;
  logic [4:0] brake_s;
  logic [6:0] torque_raw;
  logic [6:0] torque;
  logic [31:0] ramp_cyc;
  logic [31:0] brake_cyc;
  logic [6:0] delta;

  assign variant = ssb_variant_t'(config_ff[CFG_VARIANT_LSB +: 2]);
  assign sensor_en = config_ff[CFG_SENSOR_BIT];
  assign ramp_s = clamp_secs(config_ff[CFG_RAMP_LSB +: 5]);
  assign brake_s = clamp_secs(config_ff[CFG_BRAKE_LSB +: 5]);
  assign torque_raw = config_ff[CFG_TORQUE_LSB +: 7];
  assign torque = (torque_raw < TORQUE_MIN_PCT) ? TORQUE_MIN_PCT :
                  (torque_raw > TORQUE_MAX_PCT) ? TORQUE_MAX_PCT : torque_raw;
  assign ramp_cyc = secs_cycles(ramp_s);
  assign brake_cyc = secs_cycles(brake_s);
  assign delta = LEVEL_FULL - torque;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      config_ff <= CONFIG_RESET;
    end else if (REG_WR && REG_ADDR == ADDR_CONFIG) begin
      config_ff <= REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      REG_RDATA <= 32'h0;
      case (REG_ADDR)
        ADDR_CONFIG: begin
          REG_RDATA <= config_ff;
        end
        ADDR_STATUS: begin
          REG_RDATA[STS_STATE_LSB +: 3] <= state_ff;
          REG_RDATA[STS_CODE_LSB +: 4] <= code_ff;
          REG_RDATA[STS_RELAY1_BIT] <= RELAY1_ON;
          REG_RDATA[STS_RELAY2_BIT] <= RELAY2_ON;
          REG_RDATA[STS_BYPASS_BIT] <= BYPASS_ON;
          REG_RDATA[STS_BRAKE_BIT] <= BRAKE_ON;
          REG_RDATA[STS_SEMI_BIT] <= SEMI_ON;
        end
        ADDR_LEVEL: begin
          REG_RDATA[6:0] <= FIRE_LEVEL;
        end
        default: begin
          REG_RDATA <= 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command decoding
  // ----------------------------------------------------------------
  logic start_q_ff;
  logic brake_q_ff;
  logic armed_ff;
  logic pend_ff;
  logic block_ff;
  logic [31:0] win_ff;
  logic start_rise;
  logic stop_rise;
  logic btn_go;
  logic go;
  logic halt;
  logic sep;

  assign start_rise = START_IN && !start_q_ff;
  assign stop_rise = BRAKE_IN && !brake_q_ff;
  assign btn_go = pend_ff && win_ff == 32'h1;
  assign sep = variant == VAR_SEPARATE;
  // Level inputs need to be seen released once after reset before a start counts
  assign go = (variant == VAR_BUTTONS) ? btn_go : (START_IN && armed_ff);
  assign halt = (variant == VAR_BUTTONS) ? stop_rise :
                sep ? BRAKE_IN : !START_IN;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      start_q_ff <= 1'b1;
      brake_q_ff <= 1'b1;
      armed_ff <= 1'b0;
    end else begin
      start_q_ff <= START_IN;
      brake_q_ff <= BRAKE_IN;
      if (!START_IN) begin
        armed_ff <= 1'b1;
      end
    end
  end

  // A start is held back for the simultaneity window so a stop inside it wins
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pend_ff <= 1'b0;
      block_ff <= 1'b0;
      win_ff <= 32'h0;
    end else if (stop_rise) begin
      pend_ff <= 1'b0;
      block_ff <= 1'b1;
      win_ff <= P_SIMUL_CYC;
    end else if (start_rise && !block_ff && !pend_ff) begin
      pend_ff <= 1'b1;
      win_ff <= P_SIMUL_CYC;
    end else if (win_ff != 32'h0) begin
      win_ff <= win_ff - 32'h1;
      if (win_ff == 32'h1) begin
        pend_ff <= 1'b0;
        block_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault latching
  // ----------------------------------------------------------------
  logic [31:0] tmr_ff;
  logic brake_tmo;
  logic [3:0] new_code;
  logic fault_hit;

  assign brake_tmo = state_ff == ST_BRAKE && sep && BRAKE_IN &&
                     tmr_ff >= brake_cyc - 32'h1;

  // Lowest code wins when several causes appear together
  always_comb begin
    new_code = FC_NONE;
    if (brake_tmo) begin
      new_code = FC_BRAKE_TIME;
    end
    if (HEATSINK_SENSOR_FAIL) begin
      new_code = FC_HEATSINK;
    end
    if (FREQ_ERR) begin
      new_code = FC_FREQ;
    end
    if (PHASE_SEQ_ERR) begin
      new_code = FC_PHASE_SEQ;
    end
    if (PHASE_FAIL) begin
      new_code = FC_PHASE_FAIL;
    end
    if (sensor_en && THERM_SHORT) begin
      new_code = FC_SENSOR_SHORT;
    end
    if (sensor_en && (BIMETAL_OPEN || THERM_OVERTEMP || THERM_OPEN)) begin
      new_code = FC_MOTOR_TEMP;
    end
    if (THY_OVERTEMP) begin
      new_code = FC_THYRISTOR;
    end
  end

  assign fault_hit = code_ff != FC_NONE || new_code != FC_NONE;

  // Only a power cycle clears the code; nothing else writes it back
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      code_ff <= FC_NONE;
    end else if (code_ff == FC_NONE) begin
      code_ff <= new_code;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [31:0] acc_ff;
  logic [31:0] acc_sum;
  logic [31:0] span;

  assign span = (state_ff == ST_SOFTSTOP) ? brake_cyc : ramp_cyc;
  assign acc_sum = acc_ff + {25'h0, delta};

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= ST_IDLE;
      tmr_ff <= 32'h0;
      acc_ff <= 32'h0;
      level_ff <= LEVEL_OFF;
    end else if (fault_hit) begin
      state_ff <= ST_FAULT;
      level_ff <= LEVEL_OFF;
      tmr_ff <= 32'h0;
    end else begin
      tmr_ff <= tmr_ff + 32'h1;
      case (state_ff)
        ST_IDLE: begin
          tmr_ff <= 32'h0;
          if (go && !halt) begin
            state_ff <= ST_RAMP;
            level_ff <= torque;
            acc_ff <= 32'h0;
          end
        end
        ST_RECOVER: begin
          if (tmr_ff >= P_RECOVER_CYC - 32'h1) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_RAMP, ST_RUN: begin
          if (halt) begin
            tmr_ff <= 32'h0;
            acc_ff <= 32'h0;
            if (variant == VAR_SOFTSTOP) begin
              state_ff <= ST_SOFTSTOP;
            end else begin
              state_ff <= ST_BRAKE_DLY;
              level_ff <= LEVEL_OFF;
            end
          end else if (sep && !START_IN) begin
            state_ff <= ST_RECOVER;
            tmr_ff <= 32'h0;
            level_ff <= LEVEL_OFF;
          end else if (state_ff == ST_RAMP) begin
            if (tmr_ff >= ramp_cyc - 32'h1) begin
              state_ff <= ST_RUN;
              level_ff <= LEVEL_FULL;
            end else if (acc_sum >= span) begin
              acc_ff <= acc_sum - span;
              if (level_ff < LEVEL_FULL) begin
                level_ff <= level_ff + 7'h1;
              end
            end else begin
              acc_ff <= acc_sum;
            end
          end
        end
        ST_BRAKE_DLY, ST_BRAKE: begin
          if (go && !halt) begin
            state_ff <= ST_RAMP;
            level_ff <= torque;
            acc_ff <= 32'h0;
            tmr_ff <= 32'h0;
          end else if (state_ff == ST_BRAKE_DLY) begin
            if (tmr_ff >= P_BRAKE_DELAY_CYC - 32'h1) begin
              state_ff <= ST_BRAKE;
              level_ff <= torque;
              tmr_ff <= 32'h0;
            end
          end else if ((sep && !BRAKE_IN) || tmr_ff >= brake_cyc - 32'h1) begin
            state_ff <= ST_RECOVER;
            level_ff <= LEVEL_OFF;
            tmr_ff <= 32'h0;
          end
        end
        ST_SOFTSTOP: begin
          if (go && !halt) begin
            state_ff <= ST_RAMP;
            level_ff <= torque;
            acc_ff <= 32'h0;
            tmr_ff <= 32'h0;
          end else if (tmr_ff >= brake_cyc - 32'h1) begin
            state_ff <= ST_RECOVER;
            level_ff <= LEVEL_OFF;
            tmr_ff <= 32'h0;
          end else if (acc_sum >= span) begin
            acc_ff <= acc_sum - span;
            if (level_ff > torque) begin
              level_ff <= level_ff - 7'h1;
            end
          end else begin
            acc_ff <= acc_sum;
          end
        end
        ST_FAULT: begin
          tmr_ff <= 32'h0;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power stage and relays
  // ----------------------------------------------------------------
  logic conducting;
  logic cycle_busy;

  assign conducting = state_ff == ST_RAMP || state_ff == ST_BRAKE || state_ff == ST_SOFTSTOP;
  assign cycle_busy = conducting || state_ff == ST_BRAKE_DLY;

  // All power and relay outputs register from the same state so they move together
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SEMI_ON <= 1'b0;
      BYPASS_ON <= 1'b0;
      BRAKE_ON <= 1'b0;
      FIRE_LEVEL <= LEVEL_OFF;
      RELAY1_ON <= 1'b0;
      RELAY2_ON <= 1'b0;
    end else begin
      SEMI_ON <= conducting;
      BYPASS_ON <= state_ff == ST_RUN;
      BRAKE_ON <= state_ff == ST_BRAKE;
      FIRE_LEVEL <= conducting ? level_ff : LEVEL_OFF;
      if (variant == VAR_SEPARATE || variant == VAR_SOFTSTOP) begin
        RELAY1_ON <= state_ff == ST_RUN;
      end else begin
        RELAY1_ON <= cycle_busy || state_ff == ST_RUN;
      end
      RELAY2_ON <= ready_ff && state_ff != ST_FAULT;
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  logic [31:0] gr_tmr_ff;
  logic gr_ph_ff;
  logic [31:0] fl_tmr_ff;
  logic fl_on_ff;
  logic [3:0] fl_cnt_ff;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gr_tmr_ff <= 32'h0;
      gr_ph_ff <= 1'b0;
    end else if (!cycle_busy) begin
      gr_tmr_ff <= 32'h0;
      gr_ph_ff <= 1'b0;
    end else if (gr_tmr_ff >= P_GREEN_BLINK_CYC - 32'h1) begin
      gr_tmr_ff <= 32'h0;
      gr_ph_ff <= !gr_ph_ff;
    end else begin
      gr_tmr_ff <= gr_tmr_ff + 32'h1;
    end
  end

  // Code pulses: on, off, repeated code times, then a long dark pause
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fl_tmr_ff <= 32'h0;
      fl_on_ff <= 1'b0;
      fl_cnt_ff <= 4'h0;
    end else if (code_ff == FC_NONE) begin
      fl_tmr_ff <= 32'h0;
      fl_on_ff <= 1'b0;
      fl_cnt_ff <= 4'h0;
    end else if (fl_tmr_ff != 32'h0) begin
      fl_tmr_ff <= fl_tmr_ff - 32'h1;
    end else if (fl_on_ff) begin
      fl_on_ff <= 1'b0;
      if (fl_cnt_ff + 4'h1 >= code_ff) begin
        fl_cnt_ff <= 4'h0;
        fl_tmr_ff <= P_FLASH_PAUSE_CYC - 32'h1;
      end else begin
        fl_cnt_ff <= fl_cnt_ff + 4'h1;
        fl_tmr_ff <= P_FLASH_CYC - 32'h1;
      end
    end else begin
      fl_on_ff <= 1'b1;
      fl_tmr_ff <= P_FLASH_CYC - 32'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      LED_GREEN <= 1'b0;
      LED_RELAY1 <= 1'b0;
      LED_RELAY2 <= 1'b0;
    end else begin
      LED_GREEN <= AUX_SUPPLY_OK && (!cycle_busy || gr_ph_ff);
      LED_RELAY1 <= RELAY1_ON;
      LED_RELAY2 <= RELAY2_ON || fl_on_ff;
    end
  end

endmodule

// file: ssb_pkg.sv
// Constants, register map and types for the softstart and brake sequencer
package ssb_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SEC_UNIT_S = 1;
  localparam int unsigned BRAKE_DELAY_MS = 500;
  localparam int unsigned RECOVER_MS = 200;
  localparam int unsigned SIMUL_MS = 100;
  localparam int unsigned FLASH_MS = 150;
  localparam int unsigned FLASH_PAUSE_MS = 1000;
  localparam int unsigned GREEN_BLINK_MS = 250;
  localparam logic [31:0] SEC_CYC = 32'(CLK_HZ * SEC_UNIT_S);
  localparam logic [31:0] BRAKE_DELAY_CYC = 32'(CLK_HZ / 1000 * BRAKE_DELAY_MS);
  localparam logic [31:0] RECOVER_CYC = 32'(CLK_HZ / 1000 * RECOVER_MS);
  localparam logic [31:0] SIMUL_CYC = 32'(CLK_HZ / 1000 * SIMUL_MS);
  localparam logic [31:0] FLASH_CYC = 32'(CLK_HZ / 1000 * FLASH_MS);
  localparam logic [31:0] FLASH_PAUSE_CYC = 32'(CLK_HZ / 1000 * FLASH_PAUSE_MS);
  localparam logic [31:0] GREEN_BLINK_CYC = 32'(CLK_HZ / 1000 * GREEN_BLINK_MS);

  // ----------------------------------------------------------------
  // Setting limits
  // ----------------------------------------------------------------
  localparam logic [4:0] TIME_MIN_S = 5'h01;
  localparam logic [4:0] TIME_MAX_S = 5'h14;
  localparam logic [6:0] TORQUE_MIN_PCT = 7'h14;
  localparam logic [6:0] TORQUE_MAX_PCT = 7'h50;
  localparam logic [6:0] LEVEL_FULL = 7'h64;
  localparam logic [6:0] LEVEL_OFF = 7'h00;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LEVEL = 4'h8;
  localparam int CFG_VARIANT_LSB = 0;
  localparam int CFG_SENSOR_BIT = 2;
  localparam int CFG_RAMP_LSB = 8;
  localparam int CFG_TORQUE_LSB = 16;
  localparam int CFG_BRAKE_LSB = 24;
  localparam logic [31:0] CONFIG_RESET = 32'h0a320a00;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_CODE_LSB = 4;
  localparam int STS_RELAY1_BIT = 8;
  localparam int STS_RELAY2_BIT = 9;
  localparam int STS_BYPASS_BIT = 10;
  localparam int STS_BRAKE_BIT = 11;
  localparam int STS_SEMI_BIT = 12;

  // ----------------------------------------------------------------
  // Types and codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {VAR_SWITCH, VAR_BUTTONS, VAR_SEPARATE, VAR_SOFTSTOP} ssb_variant_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECOVER, ST_RAMP, ST_RUN, ST_BRAKE_DLY, ST_BRAKE, ST_SOFTSTOP, ST_FAULT
  } ssb_state_t;
  localparam logic [3:0] FC_NONE = 4'h0;
  localparam logic [3:0] FC_THYRISTOR = 4'h1;
  localparam logic [3:0] FC_MOTOR_TEMP = 4'h2;
  localparam logic [3:0] FC_SENSOR_SHORT = 4'h3;
  localparam logic [3:0] FC_PHASE_FAIL = 4'h4;
  localparam logic [3:0] FC_PHASE_SEQ = 4'h5;
  localparam logic [3:0] FC_FREQ = 4'h6;
  localparam logic [3:0] FC_HEATSINK = 4'h7;
  localparam logic [3:0] FC_BRAKE_TIME = 4'h8;

endpackage

// file: ssb_softstart_brake_properties.sv
// Concurrent checks on the ports of the softstart and brake sequencer
`timescale 1ns/1ps
module ssb_softstart_brake_properties
  import ssb_pkg::*;
#(
  parameter logic [31:0] P_BRAKE_DELAY_CYC = BRAKE_DELAY_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic AUX_SUPPLY_OK,
  input wire logic THY_OVERTEMP,
  input wire logic [6:0] FIRE_LEVEL,
  input wire logic SEMI_ON,
  input wire logic BYPASS_ON,
  input wire logic BRAKE_ON,
  input wire logic RELAY1_ON,
  input wire logic RELAY2_ON,
  input wire logic LED_GREEN,
  input wire logic LED_RELAY1,
  input wire logic LED_RELAY2
);
  // Small slack around the delay: state and outputs are one register apart
  localparam int BD_LO = int'(P_BRAKE_DELAY_CYC) - 3;
  localparam int BD_HI = int'(P_BRAKE_DELAY_CYC) + 3;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Leaving run with relay two up is a stop, not a trip
  sequence stop_seen;
    $fell(BYPASS_ON) && RELAY2_ON;
  endsequence
  sequence trip_seen;
    $rose(THY_OVERTEMP);
  endsequence
  AST_FAULT_OFF: assert property (trip_seen |-> ##[1:2] !(SEMI_ON | RELAY1_ON | RELAY2_ON))
    else $error("outputs still on after a trip");
  AST_FAULT_HOLD: assert property ($fell(RELAY2_ON) |=> !RELAY2_ON [*8])
    else $error("relay two came back while latched");
  AST_BYPASS_ALONE: assert property (BYPASS_ON |-> !SEMI_ON && !BRAKE_ON)
    else $error("bypass closed with semiconductors on");
  AST_BRAKE_CURRENT: assert property (BRAKE_ON |-> SEMI_ON)
    else $error("brake without conduction");
  AST_RAMP_UP: assert property (SEMI_ON && !BRAKE_ON && $past(SEMI_ON) && !$past(BRAKE_ON)
    |-> FIRE_LEVEL >= $past(FIRE_LEVEL))
    else $error("level fell during ramp");
  AST_BRAKE_DELAY: assert property (stop_seen |-> ##[BD_LO:BD_HI] $rose(BRAKE_ON))
    else $error("braking not started after the delay");
  AST_LED_R1: assert property (RELAY1_ON && $past(RELAY1_ON) |-> LED_RELAY1)
    else $error("relay one lamp dark");
  AST_LED_R2: assert property (RELAY2_ON && $past(RELAY2_ON) |-> LED_RELAY2)
    else $error("relay two lamp not steady");
  AST_GREEN: assert property (BYPASS_ON && $past(BYPASS_ON) && AUX_SUPPLY_OK |-> LED_GREEN)
    else $error("green lamp not steady in run");
endmodule
bind ssb_softstart_brake ssb_softstart_brake_properties #(
  .P_BRAKE_DELAY_CYC(P_BRAKE_DELAY_CYC)
) u_chk (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .AUX_SUPPLY_OK(AUX_SUPPLY_OK),
  .THY_OVERTEMP(THY_OVERTEMP), .FIRE_LEVEL(FIRE_LEVEL), .SEMI_ON(SEMI_ON),
  .BYPASS_ON(BYPASS_ON), .BRAKE_ON(BRAKE_ON), .RELAY1_ON(RELAY1_ON), .RELAY2_ON(RELAY2_ON),
  .LED_GREEN(LED_GREEN), .LED_RELAY1(LED_RELAY1), .LED_RELAY2(LED_RELAY2)
);

// file: ssb_operator_model.sv
// Operator switch, push buttons and motor sensor model
`timescale 1ns/1ps
module ssb_operator_model (
  input wire logic clk,
  output logic start_sw,
  output logic stop_btn,
  output logic [8:0] sense
);
  initial begin
    start_sw = 1'b0;
    stop_btn = 1'b0;
    sense = 9'h000;
  end
  // A new run needs a fresh start from the operator
  task automatic set_start(input logic v);
    @(posedge clk);
    start_sw <= v;
  endtask
  task automatic set_stop(input logic v);
    @(posedge clk);
    stop_btn <= v;
  endtask
  // Sensors stay tripped until the motor is cooled by command
  task automatic set_fault(input logic [8:0] v);
    @(posedge clk);
    sense <= v;
  endtask
endmodule

// file: ssb_softstart_brake_tb.sv
// Self-checking bench for the softstart and brake sequencer
`timescale 1ns/1ps
module ssb_softstart_brake_tb;
  import ssb_pkg::*;
  logic SYS_CLK, RESETN, AUX_SUPPLY_OK, REG_WR, REG_RD;
  logic [3:0] REG_ADDR;
  logic [31:0] REG_WDATA;
  wire logic [31:0] REG_RDATA;
  wire logic [6:0] FIRE_LEVEL;
  wire logic START_IN, BRAKE_IN, SEMI_ON, BYPASS_ON, BRAKE_ON, RELAY1_ON, RELAY2_ON;
  wire logic LED_GREEN, LED_RELAY1, LED_RELAY2;
  wire logic [8:0] sense;
  // Switch variant, sensors on, ramp 1 s, torque 20 %, brake 1 s
  localparam logic [31:0] CFG = 32'h01140104;
  logic [3:0] codes [9] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  logic [31:0] v;
  ssb_operator_model op (.clk(SYS_CLK), .start_sw(START_IN), .stop_btn(BRAKE_IN), .sense(sense));
  ssb_softstart_brake #(.P_SEC_CYC(32'h64), .P_BRAKE_DELAY_CYC(32'h32), .P_RECOVER_CYC(32'h14),
    .P_SIMUL_CYC(32'ha), .P_FLASH_CYC(32'h5), .P_FLASH_PAUSE_CYC(32'h14),
    .P_GREEN_BLINK_CYC(32'h5)) dut (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .START_IN(START_IN), .BRAKE_IN(BRAKE_IN),
    .AUX_SUPPLY_OK(AUX_SUPPLY_OK), .THY_OVERTEMP(sense[0]), .BIMETAL_OPEN(sense[1]),
    .THERM_OVERTEMP(sense[2]), .THERM_OPEN(sense[3]), .THERM_SHORT(sense[4]),
    .PHASE_FAIL(sense[5]), .PHASE_SEQ_ERR(sense[6]), .FREQ_ERR(sense[7]),
    .HEATSINK_SENSOR_FAIL(sense[8]), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FIRE_LEVEL(FIRE_LEVEL),
    .SEMI_ON(SEMI_ON), .BYPASS_ON(BYPASS_ON), .BRAKE_ON(BRAKE_ON), .RELAY1_ON(RELAY1_ON),
    .RELAY2_ON(RELAY2_ON), .LED_GREEN(LED_GREEN), .LED_RELAY1(LED_RELAY1),
    .LED_RELAY2(LED_RELAY2));
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // Whole plan needs well under 10000 cycles
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic rst();
    @(posedge SYS_CLK);
    RESETN <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return SEMI_ON;
      1: return BYPASS_ON;
      default: return BRAKE_ON;
    endcase
  endfunction
  // Counts edges until the chosen output reaches the level, bounded
  task automatic wait_for(input int s, input logic lv, output int k);
    k = 0;
    do begin
      @(posedge SYS_CLK);
      #1 k++;
    end while (pick(s) !== lv && k < 3000);
  endtask
  // Counts lamp pulses between two long dark pauses
  task automatic flashes(output int k);
    int lo;
    lo = 0;
    k = 0;
    while (lo < 15) begin
      @(posedge SYS_CLK);
      #1 lo = (LED_RELAY2 === 1'b0) ? lo + 1 : 0;
    end
    lo = 1;
    while (lo < 15) begin
      @(posedge SYS_CLK);
      #1 if (LED_RELAY2 === 1'b1) begin
        if (lo > 0) k++;
        lo = 0;
      end else lo++;
    end
  endtask
  initial begin
    RESETN = 1'b0;
    AUX_SUPPLY_OK = 1'b1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 4'h0;
    REG_WDATA = 32'h0;
    rst();
    chk(RELAY2_ON, 1'b1);
    AUX_SUPPLY_OK <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1 chk(LED_GREEN, 1'b0);
    @(posedge SYS_CLK);
    AUX_SUPPLY_OK <= 1'b1;
    rd(ADDR_CONFIG, v);
    chk(v, CONFIG_RESET);
    rd(4'hf, v);
    chk(v, 32'h0);
    // Every data bit is driven once; a write to a read-only address must not land
    wr(ADDR_CONFIG, 32'hffffffff);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_CONFIG, v);
    chk(v, 32'hffffffff);
    wr(ADDR_CONFIG, CFG);
    op.set_start(1'b1);
    wait_for(0, 1'b1, n);
    chk(FIRE_LEVEL, 7'h14);
    chk(RELAY1_ON, 1'b1);
    wait_for(1, 1'b1, n);
    chk(n, 100);
    op.set_start(1'b0);
    wait_for(2, 1'b1, n);
    wait_for(2, 1'b0, n);
    chk(n, 100);
    #40 chk({SEMI_ON, RELAY1_ON}, 2'b00);
    op.set_start(1'b1);
    wait_for(0, 1'b1, n);
    chk(n >= 18 && n <= 25, 1'b1);
    wait_for(1, 1'b1, n);
    op.set_start(1'b0);
    wait_for(2, 1'b1, n);
    op.set_start(1'b1);
    wait_for(2, 1'b0, n);
    chk({n <= 3, SEMI_ON}, 2'b11);
    // Start must be released so the button test below sees a real press
    op.set_start(1'b0);
    rst();
    wr(ADDR_CONFIG, CFG | 32'h1);
    op.set_start(1'b1);
    op.set_stop(1'b1);
    op.set_start(1'b0);
    op.set_stop(1'b0);
    repeat (30) @(posedge SYS_CLK);
    #1 chk(SEMI_ON, 1'b0);
    op.set_start(1'b1);
    op.set_start(1'b0);
    wait_for(0, 1'b1, n);
    chk(n <= 15, 1'b1);
    rst();
    wr(ADDR_CONFIG, CFG | 32'h2);
    op.set_start(1'b1);
    wait_for(0, 1'b1, n);
    chk(RELAY1_ON, 1'b0);
    op.set_stop(1'b1);
    wait_for(2, 1'b1, n);
    repeat (110) @(posedge SYS_CLK);
    rd(ADDR_STATUS, v);
    chk(v[7:4], FC_BRAKE_TIME);
    op.set_stop(1'b0);
    op.set_start(1'b0);
    for (int i = 0; i < 9; i++) begin
      rst();
      wr(ADDR_CONFIG, CFG);
      op.set_start(1'b1);
      wait_for(0, 1'b1, n);
      op.set_fault(9'h001 << i);
      repeat (3) @(posedge SYS_CLK);
      #1 chk({SEMI_ON, RELAY1_ON, RELAY2_ON}, 3'b000);
      rd(ADDR_STATUS, v);
      chk(v[7:4], codes[i]);
      flashes(n);
      chk(n, codes[i]);
      op.set_fault(9'h000);
      op.set_start(1'b0);
      op.set_start(1'b1);
      repeat (30) @(posedge SYS_CLK);
      #1 chk(SEMI_ON, 1'b0);
      op.set_start(1'b0);
    end
    op.set_start(1'b1);
    rst();
    repeat (30) @(posedge SYS_CLK);
    #1 chk(SEMI_ON, 1'b0);
    op.set_start(1'b0);
    op.set_start(1'b1);
    wait_for(0, 1'b1, n);
    chk(n <= 5, 1'b1);
    end_sim();
  end
endmodule
